// file: logic/lsr_defines.svh
// Offsets, field positions, reset values and timing counts of the line sensor sequencer
`ifndef LSR_DEFINES_SVH
`define LSR_DEFINES_SVH
`define LSR_OFF_CTRL 12'h000
`define LSR_OFF_PIXCNT 12'h004
`define LSR_OFF_STATUS 12'h008
`define LSR_CTRL_RUN_BIT 0
`define LSR_CTRL_RESET 32'h0000_0001
`define LSR_PIXCNT_RESET 11'h400
`define LSR_LEAD_CLKS 11'h010
`define LSR_FIRST_PIX_POS 11'h011
`define LSR_SAMPLE_END 4'h3
`define LSR_RESET_DONE 4'h6
`define LSR_FRESH_INT 4'h9
`endif

// file: logic/lsr_pkg.sv
// Types shared by the line sensor sequencer
package lsr_pkg;
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_DARK,
        RD_PIXEL
    } lsr_rd_state_t;
    typedef struct packed {
        logic dark;
        logic [10:0] index;
    } lsr_pixel_t;
    typedef struct packed {
        logic sample_hold;
        logic cap_reset;
        logic integrating;
        logic connect;
        logic bin_mode;
        logic fresh_int;
    } lsr_seq_t;
endpackage : lsr_pkg

// file: logic/lsr_sync.sv
// Two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module lsr_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    logic meta;
    logic next_meta;
    logic next_sync;
    always_comb begin
        next_meta = async_in;
        next_sync = meta;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta <= next_meta;
            sync_out <= next_sync;
        end
    end
endmodule : lsr_sync

// file: logic/lsr_ctrl.sv
// Line sensor readout and integration sequencer with APB registers
`timescale 1ns/1ps
`include "lsr_defines.svh"
// Summary of operation
// - Start on pixel clock edge restarts readout
// - Clocking past line wraps, no new sample
// - Shutter never touches readout position
// - Start condition also begins new integration
// - Fresh integration begins nine clocks after start
// - Shutter low keeps photodiodes connected
// - Shutter high disconnects photodiodes, holds charge
// - Internal reset done six clocks after start
// - First pixel at clock seventeen, dark before
// - Select pins divide pixel count by 1/2/4/8
// - Select pin picks binning or averaging
module lsr_ctrl import lsr_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line_start_in,
    input wire logic pixel_clk_in,
    input wire logic shutter_hold_in,
    input wire logic grouping_sel_bit0,
    input wire logic grouping_sel_bit1,
    input wire logic bin_or_avg_select,
    output lsr_pixel_t analog_pixel_out,
    output lsr_seq_t seq_out
);
    logic start_s, clk_s, shut_s, g0_s, g1_s, bin_s;
    logic clk_d, next_clk_d;
    logic clk_rise, start_cond;
    logic [1:0] grp;
    logic [10:0] n_eff, wrap_pos;
    logic [31:0] ctrl, next_ctrl;
    logic [10:0] pix_count, next_pix_count;
    logic [10:0] pos, next_pos;
    logic [3:0] ph, next_ph;
    lsr_rd_state_t rd, next_rd;
    lsr_pixel_t next_pix;
    lsr_seq_t next_seq;
    logic [31:0] next_prdata;
    logic run;

    // Every sensor control pin is asynchronous to pclk, so each goes through its own synchroniser
    lsr_sync u_sync_start (.pclk(pclk), .presetn(presetn), .async_in(line_start_in),
        .sync_out(start_s));
    lsr_sync u_sync_clk (.pclk(pclk), .presetn(presetn), .async_in(pixel_clk_in),
        .sync_out(clk_s));
    lsr_sync u_sync_shut (.pclk(pclk), .presetn(presetn), .async_in(shutter_hold_in),
        .sync_out(shut_s));
    lsr_sync u_sync_g0 (.pclk(pclk), .presetn(presetn), .async_in(grouping_sel_bit0),
        .sync_out(g0_s));
    lsr_sync u_sync_g1 (.pclk(pclk), .presetn(presetn), .async_in(grouping_sel_bit1),
        .sync_out(g1_s));
    lsr_sync u_sync_bin (.pclk(pclk), .presetn(presetn), .async_in(bin_or_avg_select),
        .sync_out(bin_s));

    assign run = ctrl[`LSR_CTRL_RUN_BIT];
    assign clk_rise = clk_s & ~clk_d & run;
    // Start and pixel clock share synchroniser latency, so setup/hold at the pin is kept
    assign start_cond = clk_rise & start_s;
    assign grp = {g1_s, g0_s};
    assign n_eff = pix_count >> grp;
    assign wrap_pos = n_eff + `LSR_LEAD_CLKS;
    assign pready = 1'b1;

    // Readout position: counts pixel clocks since start; the shutter is not an input here
    always_comb begin
        next_clk_d = clk_s;
        next_pos = pos;
        next_rd = rd;
        if (start_cond) begin
            next_pos = 11'h001;
            next_rd = RD_DARK;
        end else if (clk_rise) begin
            case (rd)
                RD_IDLE: next_rd = RD_IDLE;
                RD_DARK, RD_PIXEL: begin
                    if (pos >= wrap_pos) begin
                        next_pos = `LSR_FIRST_PIX_POS;
                    end else begin
                        next_pos = pos + 11'h001;
                    end
                    next_rd = (next_pos >= `LSR_FIRST_PIX_POS) ? RD_PIXEL : RD_DARK;
                end
                default: next_rd = RD_IDLE;
            endcase
        end
        next_pix.dark = (next_rd != RD_PIXEL);
        next_pix.index = (next_rd == RD_PIXEL) ? next_pos - `LSR_FIRST_PIX_POS : 11'h000;
    end

    // Integration phase: sample, capacitor reset, then integrate
    always_comb begin
        next_ph = ph;
        if (start_cond) begin
            next_ph = 4'h0;
        end else if (clk_rise && ph < `LSR_FRESH_INT) begin
            next_ph = ph + 4'h1;
        end
        next_seq.sample_hold = next_ph < `LSR_SAMPLE_END;
        next_seq.cap_reset = next_ph >= `LSR_SAMPLE_END && next_ph < `LSR_RESET_DONE;
        next_seq.integrating = next_ph >= `LSR_RESET_DONE;
        next_seq.fresh_int = clk_rise && !start_cond && ph == `LSR_FRESH_INT - 4'h1;
        next_seq.connect = ~shut_s;
        next_seq.bin_mode = bin_s && grp != 2'b00;
    end

    // APB slave, zero wait states; read data is latched in the setup cycle
    always_comb begin
        next_ctrl = ctrl;
        next_pix_count = pix_count;
        next_prdata = prdata;
        if (psel && penable && pwrite) begin
            case (paddr)
                `LSR_OFF_CTRL: next_ctrl = {31'h0, pwdata[0]};
                `LSR_OFF_PIXCNT: next_pix_count = pwdata[10:0];
                default: next_ctrl = ctrl;
            endcase
        end
        if (psel && !penable) begin
            case (paddr)
                `LSR_OFF_CTRL: next_prdata = ctrl;
                `LSR_OFF_PIXCNT: next_prdata = {21'h0, pix_count};
                `LSR_OFF_STATUS: next_prdata = {11'h0, seq_out.integrating, ph,
                    rd == RD_PIXEL, pos, 2'b00, grp};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end
    assign pslverr = psel && penable && paddr != `LSR_OFF_CTRL && paddr != `LSR_OFF_PIXCNT
        && paddr != `LSR_OFF_STATUS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_d <= 1'b0;
            pos <= 11'h000;
            rd <= RD_IDLE;
            ph <= `LSR_FRESH_INT;
            ctrl <= `LSR_CTRL_RESET;
            pix_count <= `LSR_PIXCNT_RESET;
            prdata <= 32'h0000_0000;
            analog_pixel_out <= '{dark: 1'b1, index: 11'h000};
            seq_out <= '{sample_hold: 1'b0, cap_reset: 1'b0, integrating: 1'b1,
                connect: 1'b1, bin_mode: 1'b0, fresh_int: 1'b0};
        end else begin
            clk_d <= next_clk_d;
            pos <= next_pos;
            rd <= next_rd;
            ph <= next_ph;
            ctrl <= next_ctrl;
            pix_count <= next_pix_count;
            prdata <= next_prdata;
            analog_pixel_out <= next_pix;
            seq_out <= next_seq;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_start;
        clk_rise && start_s;
    endsequence
    sequence s_quiet_rise;
        clk_rise && !start_s;
    endsequence
    a_start_readout: assert property (s_start |=> pos == 11'h001 && analog_pixel_out.dark)
        else $error("start did not restart readout");
    a_wrap_reread: assert property (s_quiet_rise ##0 (rd != RD_IDLE && pos == wrap_pos)
        |=> pos == 11'h011 && !analog_pixel_out.dark && analog_pixel_out.index == 11'h000
        && $stable(ph))
        else $error("wrap did not restart at first pixel");
    a_shutter_indep: assert property (!clk_rise |=> $stable(pos) && $stable(rd))
        else $error("position moved without a pixel clock");
    a_start_integr: assert property (s_start |=> ph == 4'h0 ##1 seq_out.sample_hold)
        else $error("start did not begin integration phase");
    a_fresh_int: assert property (seq_out.fresh_int |-> ph == 4'h9 && $past(ph) == 4'h8)
        else $error("fresh integration not at ninth clock");
    a_connect_low: assert property (!shut_s |=> seq_out.connect)
        else $error("photodiodes not connected with shutter low");
    a_disconnect: assert property (shut_s |=> !seq_out.connect)
        else $error("photodiodes connected with shutter high");
    a_reset_done: assert property ($rose(seq_out.integrating) |-> ph == 4'h6
        && !seq_out.cap_reset && $past(seq_out.cap_reset))
        else $error("integration mode not six clocks after start");
    a_first_pixel: assert property (s_quiet_rise ##0 (pos == 11'h010 && rd != RD_IDLE)
        |=> !analog_pixel_out.dark && analog_pixel_out.index == 11'h000)
        else $error("first pixel not at clock seventeen");
    a_dark_lead: assert property (rd == RD_DARK |-> analog_pixel_out.dark && pos < 11'h011)
        else $error("pixel shown during leading clocks");
    a_group_limit: assert property (!analog_pixel_out.dark |->
        analog_pixel_out.index < (pix_count >> grp))
        else $error("pixel index beyond grouped count");
    a_bin_select: assert property (##1 $stable(grp) && $stable(bin_s) |->
        seq_out.bin_mode == (bin_s && grp != 2'b00))
        else $error("binning mode does not follow select");
    a_pos_bound: assert property (rd != RD_IDLE && $stable(grp) && $stable(pix_count)
        |-> pos <= wrap_pos)
        else $error("position past wrap point");
endmodule : lsr_ctrl

// file: sim/lsr_ctl_model.sv
// Model of the external controller driving the sensor pins
`timescale 1ns/1ps
module lsr_ctl_model #(parameter bit EARLY_REL = 1'b0) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic start_req,
    input wire logic [1:0] grp_req,
    input wire logic bin_req,
    output logic pixel_clk_in,
    output logic line_start_in,
    output logic grouping_sel_bit0,
    output logic grouping_sel_bit1,
    output logic bin_or_avg_select
);
    logic [2:0] cnt;
    // Early silicon cannot group pixels, so it stays at full resolution
    assign {grouping_sel_bit1, grouping_sel_bit0} = EARLY_REL ? 2'b00 : grp_req;
    assign bin_or_avg_select = EARLY_REL ? 1'b0 : bin_req;
    // Clock stands low between frames; four cycles high, four low
    assign pixel_clk_in = run & cnt[2];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 3'h0;
            line_start_in <= 1'b0;
        end else if (run) begin
            cnt <= cnt + 3'h1;
            // Start set up two cycles before the rise, held six after it
            if (cnt == 3'h1) line_start_in <= start_req;
        end else begin
            cnt <= 3'h0;
        end
    end
endmodule : lsr_ctl_model

// file: sim/tb_line_sensor_read_integrate_ctrl.sv
// Self-checking bench of the line sensor sequencer
`timescale 1ns/1ps
module tb_line_sensor_read_integrate_ctrl;
    import lsr_pkg::*;
    localparam int NPIX = 32;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, pixel_clk_in, line_start_in, g0, g1, bsel;
    logic shutter_hold_in = 1'b0, run = 1'b0, start_req = 1'b0, bin_req = 1'b0;
    logic [1:0] grp_req = 2'h0;
    lsr_pixel_t analog_pixel_out, saved;
    lsr_seq_t seq_out;
    int n_fail = 0, checks_done = 0, seed = 32'h3585, k = 0, fi_k = 0;
    lsr_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_start_in(line_start_in), .pixel_clk_in(pixel_clk_in),
        .shutter_hold_in(shutter_hold_in), .grouping_sel_bit0(g0), .grouping_sel_bit1(g1),
        .bin_or_avg_select(bsel), .analog_pixel_out(analog_pixel_out), .seq_out(seq_out));
    lsr_ctl_model pm (.pclk(pclk), .presetn(presetn), .run(run), .start_req(start_req),
        .grp_req(grp_req), .bin_req(bin_req), .pixel_clk_in(pixel_clk_in),
        .line_start_in(line_start_in), .grouping_sel_bit0(g0), .grouping_sel_bit1(g1),
        .bin_or_avg_select(bsel));
    initial begin
        forever #20 pclk = ~pclk;
    end
    // The fresh-integration pulse lasts one cycle, so it is caught here
    always @(posedge pclk) if (seq_out.fresh_int === 1'b1) fi_k <= k;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (i == 20) chk(32'h0, 32'h1, "apb timeout");
        if (i == 20) wrap_up();
    endtask : apb
    // Waits for a pixel clock rise and lets the design's answer settle
    task automatic rise();
        int i;
        logic last;
        last = 1'b1;
        for (i = 0; i < 40 && !(pixel_clk_in === 1'b1 && last === 1'b0); i++) begin
            last = pixel_clk_in;
            @(posedge pclk);
        end
        if (i == 40) chk(32'h0, 32'h1, "pixel clock timeout");
        if (i == 40) wrap_up();
        // Drop start now: the model samples it again five clocks on, so it covers one rise
        start_req <= 1'b0;
        shutter_hold_in <= 1'($random(seed));
        repeat (5) @(posedge pclk);
        chk(32'(seq_out.connect), 32'(!shutter_hold_in), "connect");
    endtask : rise
    task automatic frame(input logic [1:0] g, input logic b);
        int n;
        logic [11:0] e;
        n = NPIX >> g;
        fi_k = 0;
        grp_req <= g;
        bin_req <= b;
        start_req <= 1'b1;
        run <= 1'b1;
        // Two rises past the line end show the wrap without a new start
        for (k = 1; k <= n + 18; k++) begin
            rise();
            e = (k > n + 16) ? 12'(k - n) : 12'(k);
            if (e <= 12'd16) chk(32'(analog_pixel_out.dark), 32'h1, "dark");
            else chk(32'(analog_pixel_out), 32'(e - 12'h011), "pixel");
            case (k)
                1: chk(32'(seq_out.sample_hold), 32'h1, "sample");
                4: chk(32'(seq_out.cap_reset), 32'h1, "cap reset");
                7: chk(32'({seq_out.integrating, seq_out.cap_reset}), 32'h2, "integ");
                12: chk(32'(fi_k), 32'd10, "fresh");
                17: chk(32'(seq_out.bin_mode), 32'(b && g != 2'h0), "bin");
                default: ;
            endcase
        end
        run <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : frame
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({seq_out.integrating, seq_out.connect}), 32'h3, "reset seq");
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h1, "ctrl");
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h400, "pixcnt");
        apb(1'b0, 12'h00C, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped");
        apb(1'b1, 12'h004, 32'(NPIX));
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'(NPIX), "pixcnt wr");
        frame(2'h0, 1'b1);
        for (int g = 0; g < 4; g++) frame(2'(g), 1'($random(seed)));
        // Last frame stops two clocks past the line end, one past the wrap: position 18, grouping code 3
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0019_8123, "status");
        // With run cleared the pixel clock must leave the output alone
        apb(1'b1, 12'h000, 32'h0);
        saved = analog_pixel_out;
        start_req <= 1'b1;
        run <= 1'b1;
        repeat (3) rise();
        chk(32'(analog_pixel_out), 32'(saved), "run off");
        wrap_up();
    end
endmodule : tb_line_sensor_read_integrate_ctrl
